// ===== bench/pic_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus handshakes and the pending outputs of the controller.
module pic_ctrl_monitor #(
    parameter int NSRC = 16,
    parameter int NEXT = 5
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] cpu_level_i,
    input wire logic irq_req_o,
    input wire logic [3:0] new_cpu_level_o,
    input wire logic [7:0] pending_vector_index_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Bus responses stand until taken and busy channels refuse new items.
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == pic_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read carries data");
    a_level_user: assert property (new_cpu_level_o <= 4'h7)
        else $error("pending level above user range");
    a_vector_range: assert property (new_cpu_level_o != 4'h0 |-> pending_vector_index_o < NSRC)
        else $error("pending index out of range");
    a_irq_follows: assert property (new_cpu_level_o != 4'h0 |-> ##[0:1] irq_req_o)
        else $error("request missing while pending");
    a_level_above: assert property (new_cpu_level_o != 4'h0 |-> new_cpu_level_o > $past(cpu_level_i))
        else $error("pending level not above core level");
    // Main scenarios seen by the checker.
    c_irq: cover property (irq_req_o);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == pic_pkg::RESP_SLVERR);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : pic_ctrl_monitor
bind pic_ctrl pic_ctrl_monitor #(.NSRC(NSRC), .NEXT(NEXT)) i_pic_ctrl_monitor (.*);
`default_nettype wire

// ===== bench/pic_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Request sources and core level seen by the controller; all change after a rising edge.
module pic_far_model (
    input wire logic clk_i,
    output logic [10:0] periph_req_o,
    output logic [4:0] ext_irq_o,
    output logic timed_disable_o,
    output logic [3:0] trap_o,
    output logic [3:0] cpu_level_o
);
    // Lines start quiet so nothing is requested out of reset.
    initial
    begin
        periph_req_o = 11'h000;
        ext_irq_o = 5'h00;
        timed_disable_o = 1'b0;
        trap_o = 4'h0;
        cpu_level_o = 4'h0;
    end
    // Raises peripheral requests and trap events for exactly one clock.
    task automatic pulse(input logic [10:0] p, input logic [3:0] t);
        @(posedge clk_i);
        periph_req_o <= p;
        trap_o <= t;
        @(posedge clk_i);
        periph_req_o <= 11'h000;
        trap_o <= 4'h0;
    endtask : pulse
    // Sets external pins, timed disable state and core level.
    task automatic levels(input logic [4:0] e, input logic d, input logic [3:0] l);
        @(posedge clk_i);
        ext_irq_o <= e;
        timed_disable_o <= d;
        cpu_level_o <= l;
    endtask : levels
endmodule : pic_far_model
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] new_cpu_level_o;
    logic [7:0] pending_vector_index_o;
    logic [4:0] ext_edge_polarity_o;
    wire [10:0] periph_req_i;
    wire [4:0] ext_irq_i;
    wire [3:0] cpu_level_i;
    wire timed_disable_active_i, usb_addr_trap_i, dma_addr_trap_i, loop_overflow_trap_i, sw_hard_trap_i;
    int fails, n_tests;
    logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    logic [15:0] rv [10] = '{16'h8000, 0, 0, 0, 0, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 0};
    logic [15:0] wm [10] = '{16'hA01F, 16'h0070, 16'h0001, 16'hFFFF, 16'hFFFF, 16'h7777, 16'h7777, 16'h7777, 16'h7777, 0};
    pic_ctrl i_pic_ctrl (.*);
    pic_far_model i_pic_far_model (.clk_i(clk_i), .periph_req_o(periph_req_i), .ext_irq_o(ext_irq_i),
        .timed_disable_o(timed_disable_active_i), .cpu_level_o(cpu_level_i),
        .trap_o({sw_hard_trap_i, loop_overflow_trap_i, dma_addr_trap_i, usb_addr_trap_i}));
    // Free running core clock.
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_up;
        fails++;
        report_and_stop();
    endtask : give_up
    // Write cycle; handshakes are seen before the edge that takes them.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = pic_pkg::RESP_OKAY);
        int n;
        logic aw, w, b;
        logic [1:0] r;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 50 && !b; n++)
        begin
            @(negedge clk_i);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!b) give_up();
        chk(r, er);
    endtask : wr
    // Read cycle; data and response are taken at the edge that sees rvalid.
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = pic_pkg::RESP_OKAY);
        int n;
        logic ar, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        for (n = 0; n < 50 && !v; n++)
        begin
            @(negedge clk_i);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!v) give_up();
        chk(d, {16'h0000, e});
        chk(r, er);
    endtask : rd
    // Lets the pending register settle, then checks it and the request line.
    task automatic pend(input logic [15:0] e);
        repeat (4) @(posedge clk_i);
        rd(pic_pkg::PENDING_OFFS, e);
        chk(irq_req_o, e != 16'h0000);
        chk({new_cpu_level_o, pending_vector_index_o}, e[11:0]);
    endtask : pend
    // Main sequence.
    initial
    begin
        fails = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        $display("reset values done");
        foreach (ra[i])
        begin
            wr(ra[i], 16'hFFFF);
            rd(ra[i], wm[i]);
            if (i == 0) chk(ext_edge_polarity_o, 5'h1F);
            wr(ra[i], rv[i]);
        end
        wr(8'h40, 16'h1234, pic_pkg::RESP_SLVERR);
        rd(8'h40, 16'h0000, pic_pkg::RESP_SLVERR);
        s_axi_wstrb <= 4'h1;
        wr(pic_pkg::ENABLE_OFFS, 16'hFFFF);
        s_axi_wstrb <= 4'hF;
        rd(pic_pkg::ENABLE_OFFS, 16'h00FF);
        wr(pic_pkg::ENABLE_OFFS, 16'h0000);
        $display("access masks done");
        i_pic_far_model.pulse(11'h000, 4'h1);
        rd(pic_pkg::SOFT_TRAP_OFFS, 16'h0040);
        i_pic_far_model.pulse(11'h000, 4'h2);
        rd(pic_pkg::SOFT_TRAP_OFFS, 16'h0060);
        i_pic_far_model.pulse(11'h000, 4'h4);
        rd(pic_pkg::SOFT_TRAP_OFFS, 16'h0070);
        i_pic_far_model.pulse(11'h000, 4'h8);
        rd(pic_pkg::HARD_TRAP_OFFS, 16'h0001);
        wr(pic_pkg::HARD_TRAP_OFFS, 16'h0000);
        rd(pic_pkg::HARD_TRAP_OFFS, 16'h0000);
        i_pic_far_model.levels(5'h00, 1'b1, 4'h0);
        rd(pic_pkg::GLOBAL_CTRL_OFFS, 16'hC000);
        $display("trap flags done");
        i_pic_far_model.levels(5'h01, 1'b0, 4'h0);
        rd(pic_pkg::FLAG_OFFS, 16'h0001);
        wr(pic_pkg::FLAG_OFFS, 16'h0000);
        wr(pic_pkg::GLOBAL_CTRL_OFFS, 16'h8001);
        i_pic_far_model.levels(5'h00, 1'b0, 4'h0);
        rd(pic_pkg::FLAG_OFFS, 16'h0001);
        wr(pic_pkg::FLAG_OFFS, 16'h0000);
        i_pic_far_model.levels(5'h01, 1'b0, 4'h0);
        rd(pic_pkg::FLAG_OFFS, 16'h0000);
        $display("edge polarity done");
        wr(pic_pkg::ENABLE_OFFS, 16'h0220);
        i_pic_far_model.pulse(11'h011, 4'h0);
        pend(16'h0405);
        wr(pic_pkg::PRIO_B_LO_OFFS, 16'h4464);
        pend(16'h0609);
        i_pic_far_model.levels(5'h01, 1'b0, 4'h6);
        pend(16'h0000);
        rd(pic_pkg::CPU_LEVEL_OFFS, 16'h0006);
        i_pic_far_model.levels(5'h01, 1'b1, 4'h0);
        pend(16'h0000);
        wr(pic_pkg::PRIO_HI_OFFS, 16'h4474);
        pend(16'h0705);
        i_pic_far_model.levels(5'h01, 1'b0, 4'h0);
        wr(pic_pkg::GLOBAL_CTRL_OFFS, 16'h0000);
        pend(16'h0000);
        wr(pic_pkg::GLOBAL_CTRL_OFFS, 16'h8000);
        wr(pic_pkg::PRIO_HI_OFFS, 16'h4404);
        pend(16'h0609);
        wr(pic_pkg::FLAG_OFFS, 16'h0000);
        pend(16'h0000);
        $display("arbitration done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// ===== src/pic_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the qualified requests into the arbiter and the winner back out.
interface pic_arb_if #(parameter int NSRC = 16);
    logic [NSRC-1:0] req;
    logic [NSRC*3-1:0] prio;
    logic win_valid;
    logic [2:0] win_prio;
    logic [7:0] win_index;
    modport ctrl (output req, output prio, input win_valid, input win_prio, input win_index);
    modport arb (input req, input prio, output win_valid, output win_prio, output win_index);
endinterface : pic_arb_if
`default_nettype wire

// ===== src/pic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// Picks the highest priority request; lowest index wins ties.
module pic_arbiter #(
    parameter int NSRC = 16
) (
    pic_arb_if.arb arb
);
    // Scan from the top index down, so a lower index overwrites an equal priority.
    always_comb
    begin
        arb.win_valid = 1'b0;
        arb.win_prio = 3'h0;
        arb.win_index = 8'h00;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (arb.req[i] && arb.prio[i*3 +: 3] >= arb.win_prio)
            begin
                arb.win_valid = 1'b1;
                arb.win_prio = arb.prio[i*3 +: 3];
                arb.win_index = 8'(i);
            end
        end
    end
endmodule : pic_arbiter
`default_nettype wire

// ===== src/pic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl #(
    parameter int NSRC = 16,
    parameter int NEXT = 5
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NSRC-NEXT-1:0] periph_req_i,
    input wire logic [NEXT-1:0] ext_irq_i,
    input wire logic timed_disable_active_i,
    input wire logic usb_addr_trap_i,
    input wire logic dma_addr_trap_i,
    input wire logic loop_overflow_trap_i,
    input wire logic sw_hard_trap_i,
    input wire logic [3:0] cpu_level_i,
    output logic irq_req_o,
    output logic [3:0] new_cpu_level_o,
    output logic [7:0] pending_vector_index_o,
    output logic [NEXT-1:0] ext_edge_polarity_o
);
    // Register state.
    logic [15:0] global_ctrl;
    logic [15:0] soft_trap_status;
    logic [15:0] hard_trap_status;
    logic [15:0] irq_flag_status;
    logic [15:0] irq_enable_mask;
    logic [15:0] irq_priority_select [4];
    logic [15:0] pending_vector_status;
    logic [NEXT-1:0] ext_prev;
    // Write channel capture and decode results.
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] rdata_next;
    logic rd_hit;
    logic wr_hit;

    pic_arb_if #(.NSRC(NSRC)) arb_bus ();

    pic_arbiter #(.NSRC(NSRC)) u_arb (
        .arb(arb_bus.arb)
    );

    // Applies byte strobes and a field mask to a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input logic [15:0] m);
        logic [15:0] r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r & m;
    endfunction : merge16

    // Write address and data are taken in either order; one held slot each.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire logic aw_fire = s_axi_awvalid && s_axi_awready;
    wire logic w_fire = s_axi_wvalid && s_axi_wready;
    wire logic wr_go = aw_held && w_held;
    wire logic [7:0] wa = aw_addr;
    wire logic sel_gc = wr_go && wa == pic_pkg::GLOBAL_CTRL_OFFS;
    wire logic sel_st = wr_go && wa == pic_pkg::SOFT_TRAP_OFFS;
    wire logic sel_ht = wr_go && wa == pic_pkg::HARD_TRAP_OFFS;
    wire logic sel_fl = wr_go && wa == pic_pkg::FLAG_OFFS;
    wire logic sel_en = wr_go && wa == pic_pkg::ENABLE_OFFS;
    wire logic sel_p0 = wr_go && wa == pic_pkg::PRIO_LO_OFFS;
    wire logic sel_p1 = wr_go && wa == pic_pkg::PRIO_HI_OFFS;
    wire logic sel_p2 = wr_go && wa == pic_pkg::PRIO_B_LO_OFFS;
    wire logic sel_p3 = wr_go && wa == pic_pkg::PRIO_B_HI_OFFS;
    wire logic [3:0] sel_p = {sel_p3, sel_p2, sel_p1, sel_p0};
    assign wr_hit = sel_gc | sel_st | sel_ht | sel_fl | sel_en | (|sel_p)
                    | (wa == pic_pkg::PENDING_OFFS) | (wa == pic_pkg::CPU_LEVEL_OFFS);

    // Edge detection on the external inputs with selectable polarity.
    wire logic [NEXT-1:0] ext_pol = global_ctrl[NEXT-1:0];
    wire logic [NEXT-1:0] ext_rise = ext_irq_i & ~ext_prev;
    wire logic [NEXT-1:0] ext_fall = ~ext_irq_i & ext_prev;
    wire logic [NEXT-1:0] ext_edge = (ext_fall & ext_pol) | (ext_rise & ~ext_pol);
    wire logic [15:0] flag_events = 16'({periph_req_i, ext_edge});

    // Hardware events set the sticky flags; a set beats a same-cycle clear.
    wire logic [15:0] soft_events = 16'({usb_addr_trap_i, dma_addr_trap_i, loop_overflow_trap_i})
                                    << pic_pkg::LOOP_TRAP_BIT;
    wire logic [15:0] next_flag = (sel_fl ? merge16(irq_flag_status, w_data, w_strb, 16'hFFFF)
                                          : irq_flag_status) | flag_events;
    wire logic [15:0] next_soft = (sel_st ? merge16(soft_trap_status, w_data, w_strb, pic_pkg::SOFT_TRAP_MASK)
                                          : soft_trap_status) | soft_events;
    wire logic [15:0] next_hard = (sel_ht ? merge16(hard_trap_status, w_data, w_strb, pic_pkg::HARD_TRAP_MASK)
                                          : hard_trap_status)
                                  | (16'(sw_hard_trap_i) << pic_pkg::SW_HARD_BIT);
    // The timed-disable bit mirrors the core's state and cannot be written.
    wire logic [15:0] gc_written = sel_gc ? merge16(global_ctrl, w_data, w_strb, pic_pkg::GLOBAL_CTRL_MASK)
                                          : global_ctrl;
    wire logic [15:0] next_gc = (gc_written & ~(16'h0001 << pic_pkg::TIMED_DIS_BIT))
                                | (16'(timed_disable_active_i) << pic_pkg::TIMED_DIS_BIT);

    // Qualification of each source toward the arbiter.
    wire logic global_en = global_ctrl[pic_pkg::GLOBAL_EN_BIT];
    wire logic timed_dis = global_ctrl[pic_pkg::TIMED_DIS_BIT];
    always_comb
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            logic [2:0] p;
            p = irq_priority_select[i/4][(i%4)*4 +: 3];
            arb_bus.prio[i*3 +: 3] = p;
            arb_bus.req[i] = irq_flag_status[i] && irq_enable_mask[i]
                             && p != 3'h0
                             && {1'b0, p} > cpu_level_i
                             && global_en
                             && (!timed_dis || p == pic_pkg::TIMED_DIS_PASS_PRIO);
        end
    end

    // Winner reported as new level and raw source index.
    wire logic [15:0] next_pending = arb_bus.win_valid
        ? {4'h0, {1'b0, arb_bus.win_prio}, arb_bus.win_index}
        : 16'h0000;

    // Global control and the pin history that the edge detectors compare against.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            global_ctrl <= pic_pkg::GLOBAL_CTRL_RST;
            ext_prev <= '0;
        end
        else
        begin
            global_ctrl <= next_gc;
            ext_prev <= ext_irq_i;
        end
    end

    // Sticky trap status flags.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            soft_trap_status <= 16'h0000;
            hard_trap_status <= 16'h0000;
        end
        else
        begin
            soft_trap_status <= next_soft;
            hard_trap_status <= next_hard;
        end
    end

    // Request flags and their enables; enables change only by software.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_flag_status <= 16'h0000;
            irq_enable_mask <= 16'h0000;
        end
        else
        begin
            irq_flag_status <= next_flag;
            if (sel_en)
                irq_enable_mask <= merge16(irq_enable_mask, w_data, w_strb, 16'hFFFF);
        end
    end

    // Arbitration result, registered so the core sees a steady level and vector.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pending_vector_status <= 16'h0000;
        else
            pending_vector_status <= next_pending;
    end

    // Priority registers, each initialised to level four in every field.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int k = 0; k < 4; k++)
                irq_priority_select[k] <= pic_pkg::PRIO_RST;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
                if (sel_p[k])
                    irq_priority_select[k] <= merge16(irq_priority_select[k], w_data, w_strb,
                                                      pic_pkg::PRIO_MASK);
        end
    end

    // Write channel handshake and capture of address and data.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // Write response: raised once both halves are held, dropped as it is taken.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pic_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read decode; unmapped addresses answer SLVERR with zero data.
    assign s_axi_arready = !s_axi_rvalid;
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            pic_pkg::GLOBAL_CTRL_OFFS: rdata_next = {16'h0000, global_ctrl};
            pic_pkg::SOFT_TRAP_OFFS: rdata_next = {16'h0000, soft_trap_status};
            pic_pkg::HARD_TRAP_OFFS: rdata_next = {16'h0000, hard_trap_status};
            pic_pkg::FLAG_OFFS: rdata_next = {16'h0000, irq_flag_status};
            pic_pkg::ENABLE_OFFS: rdata_next = {16'h0000, irq_enable_mask};
            pic_pkg::PRIO_LO_OFFS: rdata_next = {16'h0000, irq_priority_select[0]};
            pic_pkg::PRIO_HI_OFFS: rdata_next = {16'h0000, irq_priority_select[1]};
            pic_pkg::PRIO_B_LO_OFFS: rdata_next = {16'h0000, irq_priority_select[2]};
            pic_pkg::PRIO_B_HI_OFFS: rdata_next = {16'h0000, irq_priority_select[3]};
            pic_pkg::PENDING_OFFS: rdata_next = {16'h0000, pending_vector_status};
            pic_pkg::CPU_LEVEL_OFFS: rdata_next = {28'h000_0000, cpu_level_i};
            default:
            begin
                rdata_next = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read valid stands from the edge that takes the address until rready.
    wire logic ar_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_axi_rvalid <= 1'b0;
        else if (ar_fire)
            s_axi_rvalid <= 1'b1;
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Read payload, captured with the address and held while rvalid stands.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pic_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rd_hit ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
        end
    end

    // Core-facing outputs.
    assign irq_req_o = pending_vector_status[pic_pkg::LEVEL_LSB +: 4] != 4'h0;
    assign new_cpu_level_o = pending_vector_status[pic_pkg::LEVEL_LSB +: 4];
    assign pending_vector_index_o = pending_vector_status[7:0];
    assign ext_edge_polarity_o = ext_pol;
endmodule : pic_ctrl
`default_nettype wire

// ===== src/pic_pkg.sv
package pic_pkg;
    // Byte offsets of the registers on the AXI4-Lite bus.
    localparam logic [7:0] GLOBAL_CTRL_OFFS = 8'h00;
    localparam logic [7:0] SOFT_TRAP_OFFS = 8'h04;
    localparam logic [7:0] HARD_TRAP_OFFS = 8'h08;
    localparam logic [7:0] FLAG_OFFS = 8'h0C;
    localparam logic [7:0] ENABLE_OFFS = 8'h10;
    localparam logic [7:0] PRIO_LO_OFFS = 8'h14;
    localparam logic [7:0] PRIO_HI_OFFS = 8'h18;
    localparam logic [7:0] PRIO_B_LO_OFFS = 8'h1C;
    localparam logic [7:0] PRIO_B_HI_OFFS = 8'h20;
    localparam logic [7:0] PENDING_OFFS = 8'h24;
    localparam logic [7:0] CPU_LEVEL_OFFS = 8'h28;
    // Field positions.
    localparam int GLOBAL_EN_BIT = 15;
    localparam int TIMED_DIS_BIT = 14;
    localparam int SW_TRAP_EN_BIT = 13;
    localparam int USB_TRAP_BIT = 6;
    localparam int DMA_TRAP_BIT = 5;
    localparam int LOOP_TRAP_BIT = 4;
    localparam int SW_HARD_BIT = 0;
    localparam int LEVEL_LSB = 8;
    // Writable masks; everything else reads zero, except the timed-disable bit of global control.
    localparam logic [15:0] GLOBAL_CTRL_MASK = 16'hA01F;
    localparam logic [15:0] SOFT_TRAP_MASK = 16'h0070;
    localparam logic [15:0] HARD_TRAP_MASK = 16'h0001;
    localparam logic [15:0] PRIO_MASK = 16'h7777;
    // Reset values, vector base and the priority that passes timed disable.
    localparam logic [15:0] GLOBAL_CTRL_RST = 16'h8000;
    localparam logic [15:0] PRIO_RST = 16'h4444;
    localparam logic [2:0] PRIO_FIELD_RST = 3'h4;
    localparam logic [7:0] VECTOR_BASE = 8'h08;
    localparam logic [2:0] TIMED_DIS_PASS_PRIO = 3'h7;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pic_pkg
